// ==== bench/sar_adc_conversion_sequencer_bench.sv ====
/*
 * Self-checking bench: AHB-Lite master tasks, a reference of the result
 * format and timing checks. Assumes the core model and checker exist.
 */
`include "sar_seq_defines.vh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
    err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
    end end

module sar_adc_conversion_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic        evt = 1'h0, ien = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv, seed = 32'h8730;
    logic [1:0]  htrans = 2'h0;
    logic [11:0] nxt = 12'h000;
    logic [11:0] q[$]; // Samples handed out by the core model.
    wire  [31:0] hrdata;
    wire  [11:0] c_val, held;
    wire  [6:0]  c_pos, c_neg;
    wire         hready, hresp, c_en, c_clk, c_smp, c_cnv, c_diff, irq;
    wire         took;
    int          err_count = 0, comparisons = 0, act = 0;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    initial forever #25 clk = ~clk;

    // Random samples, sample log and active phase cycle count.
    always @(posedge clk) begin
        seed <= xs(seed);
        nxt  <= seed[11:0];
        if (took) q.push_back(held);
        if (c_smp || c_cnv) act <= act + 1;
    end

    sar_adc_conversion_sequencer dut (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_EVENT(evt),
        .I_CORE_SAMPLE(c_val), .O_CORE_ENABLE(c_en), .O_CORE_CLK_ADC(c_clk),
        .O_CORE_SAMPLE(c_smp), .O_CORE_CONVERT(c_cnv), .O_CORE_DIFF(c_diff),
        .O_CORE_POS(c_pos), .O_CORE_NEG(c_neg), .O_IRQ(irq));

    sar_core_model core (.clk(clk), .rst_n(rst_n), .smp(c_smp), .cnv(c_cnv),
        .nxt(nxt), .val(c_val), .held(held), .took(took));

    // One AHB-Lite single word transfer; read data lands in rdv.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        rdv = hrdata;
    endtask

    // Count edges until the sample phase shows.
    task automatic wait_smp(output int d);
        d = 0;
        while (c_smp !== 1'h1) begin
            @(posedge clk);
            d++;
        end
    endtask

    // Poll the ready flag, compare the result with the reference, clear.
    task automatic done(input int sel, input logic [3:0] ctl);
        int s;
        s = 0;
        rdv = 32'h0;
        while (rdv[0] !== 1'h1) bus(1'h0, `OFS_FLAGS, 32'h0);
        `CHK("irq", ien, irq)
        `CHK("resp", 1'h0, hresp)
        bus(1'h0, `OFS_RESULT, 32'h0);
        `CHK("samples", 1'h1, q.size() >= (1 << sel))
        repeat (1 << sel) begin
            s += ctl[1] ? int'($signed(q[0])) : int'(q[0]);
            void'(q.pop_front());
        end
        if (sel == 0 && ctl[2]) s = s >>> 2;
        if (sel > 4) s = s >>> (sel - 4);
        else if (ctl[3]) s = s <<< ((sel == 0 && ctl[2]) ? 6 : 4 - sel);
        `CHK("result", s[15:0], rdv[15:0])
        bus(1'h1, `OFS_FLAGS, 32'h1);
    endtask

    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        test_done;
    end

    initial begin
        int d1, d2, a0, sel, p;
        logic [3:0] ctl;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        bus(1'h0, 8'h24, 32'h0);
        `CHK("unmapped", 16'h0, rdv[15:0])
        bus(1'h1, `OFS_COMMAND, 32'h1);
        bus(1'h0, `OFS_COMMAND, 32'h0);
        `CHK("start off", 1'h0, rdv[0])
        // Configure first and enable last, with a warm-up of 4.
        bus(1'h1, `OFS_CONFIG, 32'h0400);
        bus(1'h1, `OFS_MUX, 32'h0305);
        bus(1'h1, `OFS_CONTROL, 32'h1);
        bus(1'h1, `OFS_COMMAND, 32'h1);
        wait_smp(d1);
        bus(1'h1, `OFS_MUX, 32'h0309);
        bus(1'h0, `OFS_COMMAND, 32'h0);
        `CHK("busy", 1'h1, rdv[0])
        `CHK("old pos", 7'h05, c_pos)
        `CHK("old neg", 7'h03, c_neg)
        `CHK("core en", 1'h1, c_en)
        done(0, 4'h1);
        bus(1'h0, `OFS_COMMAND, 32'h0);
        `CHK("idle", 1'h0, rdv[0])
        bus(1'h1, `OFS_COMMAND, 32'h1);
        wait_smp(d2);
        `CHK("new pos", 7'h09, c_pos)
        `CHK("start delay", 1'h1, d2 <= 5)
        `CHK("warm-up", 1'h1, d1 - d2 >= 8)
        done(0, 4'h1);
        // Every format mode, every accumulation count, three prescalers.
        for (int m = 0; m < 16; m++) begin
            ctl = {m[2:0], 1'h1};
            sel = m[3] ? (m * 3) % 8 : 0;
            p = m % 3;
            bus(1'h1, `OFS_CONFIG, (p << 4) | sel);
            bus(1'h1, `OFS_CONTROL, {28'h0, ctl});
            a0 = act;
            bus(1'h1, `OFS_COMMAND, 32'h1);
            wait_smp(d2);
            `CHK("diff", ctl[1], c_diff)
            bus(1'h0, `OFS_COMMAND, 32'h0);
            `CHK("held", 1'h1, rdv[0])
            done(sel, ctl);
            `CHK("span", (31 << p) << sel, act - a0)
        end
        bus(1'h1, `OFS_CONFIG, 32'h0);
        bus(1'h1, `OFS_CONTROL, 32'h1);
        bus(1'h1, `OFS_EVENT, 32'h1);
        evt <= 1'h1;
        wait_smp(d2);
        bus(1'h0, `OFS_COMMAND, 32'h0);
        `CHK("event busy", 1'h1, rdv[0])
        done(0, 4'h1);
        bus(1'h0, `OFS_COMMAND, 32'h0);
        `CHK("event end", 1'h0, rdv[0])
        repeat (40) @(posedge clk);
        `CHK("level no start", 1'h0, c_smp)
        evt <= 1'h0;
        bus(1'h1, `OFS_EVENT, 32'h0);
        evt <= 1'h1;
        repeat (20) @(posedge clk);
        `CHK("event masked", 1'h0, c_smp)
        evt <= 1'h0;
        ien = 1'h1;
        bus(1'h1, `OFS_INTCTRL, 32'h1);
        bus(1'h1, `OFS_COMMAND, 32'h1);
        done(0, 4'h1);
        repeat (3) @(posedge clk);
        `CHK("irq clear", 1'h0, irq)
        // Free running: three results, then stop it.
        bus(1'h1, `OFS_CONTROL, 32'h11);
        bus(1'h1, `OFS_COMMAND, 32'h1);
        repeat (3) begin
            done(0, 4'h1);
            bus(1'h0, `OFS_COMMAND, 32'h0);
            `CHK("free busy", 1'h1, rdv[0])
        end
        bus(1'h1, `OFS_CONTROL, 32'h1);
        done(0, 4'h1);
        repeat (60) @(posedge clk);
        bus(1'h0, `OFS_COMMAND, 32'h0);
        `CHK("free stop", 1'h0, rdv[0])
        bus(1'h1, `OFS_CONTROL, 32'h0);
        bus(1'h1, `OFS_COMMAND, 32'h1);
        repeat (20) @(posedge clk);
        `CHK("off clk", 1'h0, c_clk)
        `CHK("off smp", 1'h0, c_smp)
        test_done;
    end
endmodule // sar_adc_conversion_sequencer_bench

// ==== bench/sar_core_model.sv ====
/*
 * Behavioural model of the analog multiplexer and SAR core.
 * Assumes the sequencer marks its sample and convert phases.
 */
module sar_core_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Phase marks from the sequencer.
    input  wire logic        smp,
    input  wire logic        cnv,
    // Next random value from the bench.
    input  wire logic [11:0] nxt,
    // Sample to the sequencer and a copy for the bench.
    output logic      [11:0] val,
    output logic      [11:0] held = 12'h000,
    output logic             took = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       smp_d = 1'h0; // Previous sample mark.
    logic [1:0] hold  = 2'h0; // Cycles left with a valid sample.

    // Latch a value as each sample phase begins and keep it valid through
    // the formatting cycles that follow the conversion.
    always @(posedge clk) begin
        smp_d <= smp;
        took  <= smp && !smp_d && rst_n;
        if (smp && !smp_d) begin
            held <= nxt;
        end
        if (!rst_n) begin
            hold <= 2'h0;
        end else if (cnv) begin
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end

    // Outside the valid span the line shows the inverse value.
    assign val = (cnv || hold != 2'h0) ? held : ~held;
endmodule // sar_core_model

// ==== bench/sar_seq_checker.sv ====
/*
 * Concurrent checks on the converter side of the sequencer.
 * Assumes binding to the sequencer top; one clock domain.
 */
module sar_seq_checker (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RST_N,
    input wire logic       O_CORE_ENABLE,
    input wire logic       O_CORE_CLK_ADC,
    input wire logic       O_CORE_SAMPLE,
    input wire logic       O_CORE_CONVERT,
    input wire logic       O_CORE_DIFF,
    input wire logic [6:0] O_CORE_POS,
    input wire logic [6:0] O_CORE_NEG
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    logic       clk_d; // Converter clock one cycle back.
    logic [5:0] tog_s; // Converter clock edges in the sample phase.
    logic [5:0] tog_c; // Converter clock edges in the convert phase.

    // Count converter clock edges inside each phase.
    always @(posedge I_CORE_CLK) begin
        clk_d <= O_CORE_CLK_ADC;
        if (!I_RST_N || !O_CORE_SAMPLE) begin
            tog_s <= 6'h00;
        end else if (O_CORE_CLK_ADC != clk_d) begin
            tog_s <= tog_s + 6'h01;
        end
        if (!I_RST_N || !O_CORE_CONVERT) begin
            tog_c <= 6'h00;
        end else if (O_CORE_CLK_ADC != clk_d) begin
            tog_c <= tog_c + 6'h01;
        end
    end

    // Formatting: two quiet cycles with the prescaler held.
    sequence s_format;
        (!O_CORE_CLK_ADC && !O_CORE_SAMPLE && !O_CORE_CONVERT) [*2];
    endsequence

    a_clk_needs_en: assert property (O_CORE_CLK_ADC |-> O_CORE_ENABLE)
        else $error("converter clock runs while disabled");
    a_off_is_quiet: assert property (!O_CORE_ENABLE [*3] |->
        !O_CORE_SAMPLE && !O_CORE_CONVERT)
        else $error("phase active while disabled");
    a_sample_to_conv: assert property ($fell(O_CORE_SAMPLE) |-> O_CORE_CONVERT)
        else $error("sampling not followed by conversion");
    a_conv_after_smp: assert property ($rose(O_CORE_CONVERT) |->
        $past(O_CORE_SAMPLE))
        else $error("conversion without sampling");
    a_format_gap: assert property ($fell(O_CORE_CONVERT) |-> s_format)
        else $error("no formatting gap after conversion");
    a_inputs_held: assert property (O_CORE_CONVERT |-> $stable(O_CORE_POS)
        && $stable(O_CORE_NEG) && $stable(O_CORE_DIFF))
        else $error("input selection changed mid conversion");
    a_sample_len: assert property ($fell(O_CORE_SAMPLE) |->
        tog_s inside {[3:5]})
        else $error("sample phase not two converter cycles");
    a_convert_len: assert property ($fell(O_CORE_CONVERT) |->
        tog_c inside {[26:28]})
        else $error("convert phase not 13.5 converter cycles");
endmodule // sar_seq_checker

bind sar_adc_conversion_sequencer sar_seq_checker u_chk (
    .I_CORE_CLK    (I_CORE_CLK),
    .I_RST_N       (I_RST_N),
    .O_CORE_ENABLE (O_CORE_ENABLE),
    .O_CORE_CLK_ADC(O_CORE_CLK_ADC),
    .O_CORE_SAMPLE (O_CORE_SAMPLE),
    .O_CORE_CONVERT(O_CORE_CONVERT),
    .O_CORE_DIFF   (O_CORE_DIFF),
    .O_CORE_POS    (O_CORE_POS),
    .O_CORE_NEG    (O_CORE_NEG)
);

// ==== src/sar_adc_conversion_sequencer.v ====
/*
 * Conversion sequencer for a 12-bit SAR converter: AHB-Lite register
 * slave, software and event start, converter clock prescaler, phase
 * sequence, free running, accumulation and result formatting.
 * Assumes the converter core returns a 12-bit sample on I_CORE_SAMPLE,
 * valid when the conversion phase ends, and that the event line is
 * synchronous to I_CORE_CLK.
 */
// Behaviour
// - Start bit begins conversion, clears at end unless free running.
// - Channel changes apply after current conversion.
// - Completed operation stores result, sets ready.
// - Interrupt when ready flag and enable.
// - Ready flag set regardless of enable.
// - Event rising edge starts when enabled.
// - Event start sets start bit too.
// - Free running restarts after each completion.
// - Prescaler reset idle, restarts each conversion.
// - Conversion starts one clock after trigger.
// - Start-up, sample, convert, format order.
// - Single conversion 15.5 slow plus 4.
// - Accumulation count taken, accumulator cleared.
// - Accumulation always uses 12-bit samples.
// - Start bit held over all accumulated samples.
// - Warm-up delay holds off sampling.
// - Disabled converter performs no conversions.
// - Ten or twelve bit result selectable.
// - Single-ended or differential measurement.
// - Right justified default, left optional.
// - Unsigned single-ended, sign-extended differential.
// - Large sums truncate low bits to fit.
`include "sar_seq_defines.vh"

module sar_adc_conversion_sequencer #(
    parameter PRE_W = 4 // Width of the prescaler divide field.
) (
    // Clock and reset.
    input  wire        I_CORE_CLK,
    input  wire        I_RST_N,
    // AHB-Lite slave.
    input  wire        I_HSEL,
    input  wire [31:0] I_HADDR,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire [31:0] I_HWDATA,
    input  wire        I_HREADY,
    output reg  [31:0] O_HRDATA,
    output reg         O_HREADYOUT,
    output reg         O_HRESP,
    // Event input and converter core.
    input  wire        I_EVENT,
    input  wire [11:0] I_CORE_SAMPLE,
    output reg         O_CORE_ENABLE,
    output reg         O_CORE_CLK_ADC,
    output reg         O_CORE_SAMPLE,
    output reg         O_CORE_CONVERT,
    output reg         O_CORE_DIFF,
    output reg  [6:0]  O_CORE_POS,
    output reg  [6:0]  O_CORE_NEG,
    // Interrupt request.
    output reg         O_IRQ
);

    // Software visible registers.
    reg [4:0]  control_reg;   // Enable, differential, 10-bit, left, free run.
    reg [15:0] config_reg;    // Accumulation, prescaler, warm-up fields.
    reg [14:0] mux_reg;       // Positive and negative input selects.
    reg        event_en_reg;  // Event start enable.
    reg        int_en_reg;    // Result-ready interrupt enable.
    reg        ready_reg;     // Result-ready flag.
    reg [15:0] result_reg;    // Formatted result.
    reg        start_reg;     // Start bit, high while a conversion runs.

    // Sequencer state.
    reg [2:0]  state_reg;     // Current phase.
    reg [1:0]  pcnt_reg;      // Peripheral clock phase counter.
    reg [4:0]  acnt_reg;      // Converter clock phase counter.
    reg [7:0]  warm_reg;      // Remaining warm-up converter cycles.
    reg        warm_done_reg; // Warm-up completed since enable.
    reg [7:0]  nleft_reg;     // Samples still to take.
    reg [`ACC_W-1:0] acc_reg; // Running sum.
    reg [PRE_W:0] pre_reg;    // Prescaler counter.
    reg        event_d_reg;   // Delayed event for edge detection.
    reg        go_reg;        // Trigger taken, start next cycle.

    // Bus address phase capture.
    reg        wr_pend_reg;   // Pending write data phase.
    reg [7:0]  wr_addr_reg;   // Captured write offset.

    // Decoded fields.
    wire [2:0] acc_sel = config_reg[`CFG_ACC_HI:`CFG_ACC_LO];
    wire [3:0] pre_sel = config_reg[`CFG_PRE_HI:`CFG_PRE_LO];
    wire [7:0] warm_sel = config_reg[`CFG_WARM_HI:`CFG_WARM_LO];
    wire       enabled = control_reg[`CTL_ENABLE];

    // Bus decode.
    wire bus_act = I_HSEL && I_HREADY && I_HTRANS[1];
    wire [7:0] boff = I_HADDR[7:0];
    wire wr_cmd = wr_pend_reg && (wr_addr_reg == `OFS_COMMAND);
    wire sw_start = wr_cmd && I_HWDATA[`BIT_START];
    wire flag_clr = wr_pend_reg && (wr_addr_reg == `OFS_FLAGS) &&
                    I_HWDATA[`BIT_RDY];

    // Prescaler tick: divide by two to the power of the select plus one.
    wire [PRE_W:0] pre_max = {{PRE_W{1'b0}}, 1'b1} << pre_sel;
    wire pre_half = (pre_reg == pre_max - {{PRE_W{1'b0}}, 1'b1});
    wire running = (state_reg == `ST_WARMUP) ||
                   (state_reg == `ST_SAMPLE) || (state_reg == `ST_CONVERT);
    wire half_tick = running && pre_half;

    // Trigger edge and completion.
    wire ev_rise = I_EVENT && !event_d_reg;
    wire trig = enabled && (state_reg == `ST_IDLE) && !go_reg &&
                (sw_start || (event_en_reg && ev_rise));
    wire fmt_end = (state_reg == `ST_FORMAT) && (pcnt_reg == `FORMAT_CYC - 2'h1);
    wire last = (nleft_reg == 8'h01);
    wire op_done = fmt_end && last;

    // Sum including the final sample, always at 12 bits.
    wire sx = I_CORE_SAMPLE[11] && control_reg[`CTL_DIFF]; // Sign bit.
    wire [`ACC_W-1:0] sum_next = acc_reg +
        {{(`ACC_W-`SAMPLE_W){sx}}, I_CORE_SAMPLE};

    // Formatting of the finished operation into 16 bits.
    reg [15:0] fmt;
    reg [11:0] s12;
    reg [`ACC_W-1:0] wide; // Sum shifted down to fit 16 bits.
    always @* begin
        s12 = sum_next[11:0];
        wide = sum_next;
        fmt = 16'h0000;
        if (acc_sel == 3'h0) begin
            // Single sample: width by resolution, sign by mode.
            if (control_reg[`CTL_RES10]) begin
                fmt = control_reg[`CTL_DIFF] ?
                      {{6{s12[11]}}, s12[11:2]} :
                      {6'h00, s12[11:2]};
                if (control_reg[`CTL_LEFT])
                    fmt = {s12[11:2], 6'h00};
            end else begin
                fmt = control_reg[`CTL_DIFF] ?
                      {{4{s12[11]}}, s12} :
                      {4'h0, s12};
                if (control_reg[`CTL_LEFT])
                    fmt = {s12, 4'h0};
            end
        end else if (acc_sel > 3'h4) begin
            // Beyond 16 samples only the overflowing low bits are dropped.
            if (control_reg[`CTL_DIFF])
                wide = $signed(sum_next) >>> (acc_sel - 3'h4);
            else
                wide = sum_next >> (acc_sel - 3'h4);
            fmt = wide[15:0];
        end else begin
            fmt = sum_next[15:0];
            if (control_reg[`CTL_LEFT])
                fmt = sum_next[15:0] << (3'h4 - acc_sel);
        end
    end

    // Register write, flag and start-bit handling.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            control_reg  <= `RST_CONTROL;
            config_reg   <= `RST_CONFIG;
            mux_reg      <= `RST_MUX;
            event_en_reg <= 1'b0;
            int_en_reg   <= 1'b0;
            ready_reg    <= 1'b0;
            result_reg   <= 16'h0000;
            start_reg    <= 1'b0;
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= 8'h00;
            event_d_reg  <= 1'b0;
        end else begin
            wr_pend_reg <= bus_act && I_HWRITE;
            wr_addr_reg <= boff;
            event_d_reg <= I_EVENT;
            if (wr_pend_reg) begin
                case (wr_addr_reg)
                    `OFS_CONTROL: control_reg <= I_HWDATA[4:0];
                    `OFS_CONFIG:  config_reg  <= I_HWDATA[15:0];
                    `OFS_MUX:     mux_reg     <= I_HWDATA[14:0];
                    `OFS_EVENT:   event_en_reg <= I_HWDATA[`BIT_EVENT_EN];
                    `OFS_INTCTRL: int_en_reg  <= I_HWDATA[`BIT_RDY];
                    default: ;
                endcase
            end
            // Start bit set by either trigger, cleared at completion outside free running.
            if (trig)
                start_reg <= 1'b1;
            else if (op_done && !control_reg[`CTL_FREE_RUNNING_MODE])
                start_reg <= 1'b0;
            else if (!enabled)
                start_reg <= 1'b0;
            // Ready flag: a new result wins over a software clear.
            if (op_done) begin
                ready_reg  <= 1'b1;
                result_reg <= fmt;
            end else if (flag_clr) begin
                ready_reg <= 1'b0;
            end
        end
    end

    // Phase sequencer, prescaler and accumulator.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            state_reg     <= `ST_IDLE;
            pcnt_reg      <= 2'h0;
            acnt_reg      <= 5'h00;
            warm_reg      <= 8'h00;
            warm_done_reg <= 1'b0;
            nleft_reg     <= 8'h00;
            acc_reg       <= {`ACC_W{1'b0}};
            pre_reg       <= {(PRE_W+1){1'b0}};
            go_reg        <= 1'b0;
            O_CORE_CLK_ADC <= 1'b0;
            O_CORE_POS    <= 7'h00;
            O_CORE_NEG    <= 7'h00;
            O_CORE_DIFF   <= 1'b0;
        end else begin
            go_reg <= trig;
            // Prescaler runs only in slow phases, else held in reset.
            if (!running || pre_half)
                pre_reg <= {(PRE_W+1){1'b0}};
            else
                pre_reg <= pre_reg + {{PRE_W{1'b0}}, 1'b1};
            if (!running || !enabled)
                O_CORE_CLK_ADC <= 1'b0;
            else if (half_tick)
                O_CORE_CLK_ADC <= !O_CORE_CLK_ADC;
            if (!enabled)
                warm_done_reg <= 1'b0;
            case (state_reg)
                `ST_IDLE: begin
                    if (go_reg) begin
                        // Latch channels and mode for this operation.
                        O_CORE_POS <= mux_reg[`MUX_POS_HI:`MUX_POS_LO];
                        O_CORE_NEG <= mux_reg[`MUX_NEG_HI:`MUX_NEG_LO];
                        O_CORE_DIFF <= control_reg[`CTL_DIFF];
                        nleft_reg <= 8'h01 << acc_sel;
                        acc_reg <= {`ACC_W{1'b0}};
                        pcnt_reg <= 2'h0;
                        state_reg <= `ST_STARTUP;
                    end
                end
                `ST_STARTUP: begin
                    // One start-up cycle after the trigger cycle.
                    if (pcnt_reg == `STARTUP_CYC - 2'h1) begin
                        acnt_reg <= 5'h00;
                        warm_reg <= warm_sel;
                        state_reg <= warm_done_reg ? `ST_SAMPLE : `ST_WARMUP;
                    end else
                        pcnt_reg <= pcnt_reg + 2'h1;
                end
                `ST_WARMUP: begin
                    // Sampling waits out the programmed warm-up.
                    if (warm_reg == 8'h00) begin
                        warm_done_reg <= 1'b1;
                        state_reg <= `ST_SAMPLE;
                    end else if (half_tick && O_CORE_CLK_ADC)
                        warm_reg <= warm_reg - 8'h01;
                end
                `ST_SAMPLE: begin
                    // Two converter clock cycles, four half periods.
                    if (half_tick) begin
                        if (acnt_reg == (`SAMPLE_ADC << 1) - 5'h01) begin
                            acnt_reg <= 5'h00;
                            state_reg <= `ST_CONVERT;
                        end else
                            acnt_reg <= acnt_reg + 5'h01;
                    end
                end
                `ST_CONVERT: begin
                    // Thirteen and a half converter clock cycles.
                    if (half_tick) begin
                        if (acnt_reg == `CONVERT_HALF - 5'h01) begin
                            pcnt_reg <= 2'h0;
                            state_reg <= `ST_FORMAT;
                        end else
                            acnt_reg <= acnt_reg + 5'h01;
                    end
                end
                `ST_FORMAT: begin
                    // Two formatting cycles per sample.
                    if (pcnt_reg == `FORMAT_CYC - 2'h1) begin
                        acc_reg <= sum_next;
                        nleft_reg <= nleft_reg - 8'h01;
                        acnt_reg <= 5'h00;
                        if (!last)
                            state_reg <= `ST_SAMPLE;
                        else if (control_reg[`CTL_FREE_RUNNING_MODE] && enabled) begin
                            nleft_reg <= 8'h01 << acc_sel;
                            acc_reg <= {`ACC_W{1'b0}};
                            O_CORE_POS <= mux_reg[`MUX_POS_HI:`MUX_POS_LO];
                            O_CORE_NEG <= mux_reg[`MUX_NEG_HI:`MUX_NEG_LO];
                            O_CORE_DIFF <= control_reg[`CTL_DIFF];
                            pcnt_reg <= 2'h0;
                            state_reg <= `ST_STARTUP;
                        end else
                            state_reg <= `ST_IDLE;
                    end else
                        pcnt_reg <= pcnt_reg + 2'h1;
                end
                default: state_reg <= `ST_IDLE;
            endcase
            // Disabling stops any conversion at once.
            if (!enabled)
                state_reg <= `ST_IDLE;
        end
    end

    // Core strobes, interrupt and bus answers, all registered.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            O_CORE_ENABLE  <= 1'b0;
            O_CORE_SAMPLE  <= 1'b0;
            O_CORE_CONVERT <= 1'b0;
            O_IRQ          <= 1'b0;
            O_HRDATA       <= 32'h00000000;
            O_HREADYOUT    <= 1'b1;
            O_HRESP        <= 1'b0;
        end else begin
            O_CORE_ENABLE  <= enabled;
            O_CORE_SAMPLE  <= (state_reg == `ST_SAMPLE);
            O_CORE_CONVERT <= (state_reg == `ST_CONVERT);
            O_IRQ          <= ready_reg && int_en_reg;
            O_HREADYOUT    <= 1'b1;
            O_HRESP        <= 1'b0;
            if (bus_act && !I_HWRITE) begin
                case (boff)
                    `OFS_CONTROL: O_HRDATA <= {27'h0000000, control_reg};
                    `OFS_CONFIG:  O_HRDATA <= {16'h0000, config_reg};
                    `OFS_MUX:     O_HRDATA <= {17'h00000, mux_reg};
                    `OFS_COMMAND: O_HRDATA <= {31'h00000000, start_reg};
                    `OFS_EVENT:   O_HRDATA <= {31'h00000000, event_en_reg};
                    `OFS_INTCTRL: O_HRDATA <= {31'h00000000, int_en_reg};
                    `OFS_FLAGS:   O_HRDATA <= {31'h00000000, ready_reg};
                    `OFS_RESULT:  O_HRDATA <= {16'h0000, result_reg};
                    `OFS_SAMPLE:  O_HRDATA <= {29'h00000000, state_reg};
                    default:      O_HRDATA <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // sar_adc_conversion_sequencer

// ==== src/sar_seq_defines.vh ====
/*
 * Constants for the SAR converter conversion sequencer: register offsets,
 * field positions, reset values, state codes and timing counts.
 * Assumes inclusion by the sequencer top and the verification side.
 */
`ifndef SAR_SEQ_DEFINES_VH
`define SAR_SEQ_DEFINES_VH

// Register byte offsets on the AHB-Lite bus.
`define OFS_CONTROL    8'h00
`define OFS_CONFIG     8'h04
`define OFS_MUX        8'h08
`define OFS_COMMAND    8'h0C
`define OFS_EVENT      8'h10
`define OFS_INTCTRL    8'h14
`define OFS_FLAGS      8'h18
`define OFS_RESULT     8'h1C
`define OFS_SAMPLE     8'h20

// Control register fields.
`define CTL_ENABLE     0
`define CTL_DIFF       1
`define CTL_RES10      2
`define CTL_LEFT       3
`define CTL_FREE_RUNNING_MODE    4

// Configuration register fields.
`define CFG_ACC_LO     0
`define CFG_ACC_HI     2
`define CFG_PRE_LO     4
`define CFG_PRE_HI     7
`define CFG_WARM_LO    8
`define CFG_WARM_HI    15

// Mux register fields.
`define MUX_POS_LO     0
`define MUX_POS_HI     6
`define MUX_NEG_LO     8
`define MUX_NEG_HI     14

// Single-bit fields of command, event, interrupt and flag registers.
`define BIT_START      0
`define BIT_EVENT_EN   0
`define BIT_RDY        0

// Reset values.
`define RST_CONTROL    5'h00
`define RST_CONFIG     16'h0000
`define RST_MUX        15'h0000

// Sequencer state codes.
`define ST_IDLE        3'h0
`define ST_STARTUP     3'h1
`define ST_WARMUP      3'h2
`define ST_SAMPLE      3'h3
`define ST_CONVERT     3'h4
`define ST_FORMAT      3'h5

// Phase lengths: start-up and format in peripheral clocks, sampling in
// converter clocks, conversion in converter half periods (13.5 cycles).
`define STARTUP_CYC    2'h1
`define FORMAT_CYC     2'h2
`define SAMPLE_ADC     5'h02
`define CONVERT_HALF   5'h1B

// Result widths.
`define SAMPLE_W       12
`define ACC_W          19

`endif
